// >>> pcm_defines.svh
// constants shared by both ends of the card memory cycle link
// assumes a single 125 MHz ref_clk on each end
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH

// ============================================================
// bus shape
`define PCM_ADDR_W 26
`define PCM_DATA_W 16
`define PCM_BYTE_W 8
`define PCM_SYNC_STAGES 2

// ============================================================
// byte enable codes on the user side
`define PCM_BE_LOW 2'h1
`define PCM_BE_HIGH 2'h2
`define PCM_BE_WORD 2'h3
`define PCM_BE_NONE 2'h0

// ============================================================
// host timing, ns as figures and cycles derived from the clock
`define PCM_CLK_NS 8
`define PCM_SETUP_NS 16
`define PCM_STROBE_NS 64
`define PCM_HOLD_NS 16
`define PCM_GAP_NS 48
`define PCM_NS2CYC(t) (8'((((t) + `PCM_CLK_NS - 1) / `PCM_CLK_NS)))
`define PCM_SETUP_CYC `PCM_NS2CYC(`PCM_SETUP_NS)
`define PCM_STROBE_CYC `PCM_NS2CYC(`PCM_STROBE_NS)
`define PCM_HOLD_CYC `PCM_NS2CYC(`PCM_HOLD_NS)
`define PCM_GAP_CYC `PCM_NS2CYC(`PCM_GAP_NS)
`define PCM_CNT_ONE 8'h01
`define PCM_CNT_ZERO 8'h00

// ============================================================
// idle pin level and zero fill byte
`define PCM_BYTE_IDLE 8'hFF
`define PCM_BYTE_ZERO 8'h00

`endif

// >>> pcm_pkg.sv
// types shared by both ends of the card memory cycle link
// assumes pcm_defines.svh is on the include path
`include "pcm_defines.svh"

package pcm_pkg;

    // ============================================================
    // lane usage of one cycle
    typedef enum logic [1:0]
    {
        PCM_LANE_NONE = 2'b00,
        PCM_LANE_LOW = 2'b01,
        PCM_LANE_HIGH = 2'b10,
        PCM_LANE_WORD = 2'b11
    } pcm_lane_e;

    typedef enum logic [2:0]
    {
        PCM_C_IDLE = 3'b000,
        PCM_C_WAIT = 3'b001,
        PCM_C_HOLD = 3'b010
    } pcm_card_state_e;

    typedef enum logic [2:0]
    {
        PCM_H_IDLE = 3'b000,
        PCM_H_SETUP = 3'b001,
        PCM_H_STROBE = 3'b010,
        PCM_H_HOLD = 3'b011,
        PCM_H_GAP = 3'b100
    } pcm_host_state_e;

    typedef logic [`PCM_ADDR_W-1:0] pcm_addr_t;
    typedef logic [`PCM_DATA_W-1:0] pcm_data_t;

    // low enable alone is a byte on D[7:0], high alone the odd byte
    function automatic pcm_lane_e pcm_lane(input logic ce1_n,
                                           input logic ce2_n);
        pcm_lane_e l;
        l = pcm_lane_e'({~ce2_n, ~ce1_n});
        return l;
    endfunction

endpackage

// >>> pcm_if.sv
// pin level link between the socket host and the card target
// card enables, strobes and wait are active low; wait has a pull-up
`timescale 1ns/1ps
`include "pcm_defines.svh"

interface pcm_if;
    // ============================================================
    // host driven pins
    logic [`PCM_ADDR_W-1:0] addr;
    logic reg_n;
    logic ce1_n;
    logic ce2_n;
    logic oe_n;
    logic we_n;
    logic bus_reset;
    logic [`PCM_DATA_W-1:0] h_d_o;
    logic [1:0] h_d_oe;
    // ============================================================
    // card driven pins
    logic [`PCM_DATA_W-1:0] c_d_o;
    logic [1:0] c_d_oe;
    logic c_wait_o;
    logic c_wait_oe;
    // ============================================================
    // resolved wires, pulled high when nobody drives
    logic [`PCM_DATA_W-1:0] data;
    logic wait_n;

    genvar g;
    for (g = 0; g < `PCM_DATA_W / `PCM_BYTE_W; g++)
    begin : lane
        assign data[g*`PCM_BYTE_W +: `PCM_BYTE_W] =
            c_d_oe[g] ? c_d_o[g*`PCM_BYTE_W +: `PCM_BYTE_W] :
            h_d_oe[g] ? h_d_o[g*`PCM_BYTE_W +: `PCM_BYTE_W] :
            `PCM_BYTE_IDLE;
    end
    assign wait_n = c_wait_oe ? c_wait_o : 1'b1;

    modport host
    (
        output addr, reg_n, ce1_n, ce2_n, oe_n, we_n, bus_reset,
        output h_d_o, h_d_oe,
        input data, wait_n
    );
    modport card
    (
        input addr, reg_n, ce1_n, ce2_n, oe_n, we_n, bus_reset,
        output c_d_o, c_d_oe, c_wait_o, c_wait_oe,
        input data
    );
endinterface

// >>> pcm_card.sv
// card end: turns socket memory cycles into user requests
// assumes the user side answers each request with one ack pulse
`timescale 1ns/1ps
`include "pcm_defines.svh"

// Overview of operation
// - 26-bit address, attribute space flagged via reg
// - cycle framed by card enable assert and release
// - host keeps reg inactive for common memory
// - low enable alone: byte on D[7:0] by A0
// - both enables: full 16-bit word transfer
// - high enable alone: odd byte on D[15:8]
// - output enable low: card drives read lanes
// - we low, oe high: card captures write lanes
// - card holds wait low until access completes
// - all bus controls are asynchronous, no clock
// - bus reset returns card configuration to reset
// - highest index is most significant bit
module pcm_card
(
    input wire logic ref_clk,
    input wire logic rst_n,
    pcm_if.card bus,
    output logic usr_req,
    output logic usr_wr,
    output logic usr_attr,
    output pcm_pkg::pcm_addr_t usr_addr,
    output logic [1:0] usr_be,
    output pcm_pkg::pcm_data_t usr_wdata,
    input wire logic usr_ack,
    input wire pcm_pkg::pcm_data_t usr_rdata,
    output logic cfg_reset
);
    import pcm_pkg::*;

    localparam int SW = `PCM_ADDR_W + `PCM_DATA_W + 6;

    // ============================================================
    // synchronisers
    // address and data ride along with the strobes; they are stable
    // while a strobe is low, so the extra latency costs nothing
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync_rst;

    assign sync_rst = {{(`PCM_ADDR_W + `PCM_DATA_W){1'b0}}, 6'h1F};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sync1 <= sync_rst;
            sync2 <= sync_rst;
        end
        else
        begin
            sync1 <= {bus.addr, bus.data, bus.bus_reset, bus.reg_n,
                      bus.we_n, bus.oe_n, bus.ce2_n, bus.ce1_n};
            sync2 <= sync1;
        end
    end

    pcm_addr_t a_s;
    pcm_data_t d_s;
    logic reset_s;
    logic reg_s_n;
    logic we_s_n;
    logic oe_s_n;
    logic ce2_s_n;
    logic ce1_s_n;

    assign {a_s, d_s, reset_s, reg_s_n, we_s_n, oe_s_n, ce2_s_n,
            ce1_s_n} = sync2;

    // ============================================================
    // cycle decode
    pcm_lane_e lane_s;
    logic ce_act;
    logic rd_strobe;
    logic wr_strobe;

    assign lane_s = pcm_lane(ce1_s_n, ce2_s_n);
    assign ce_act = lane_s != PCM_LANE_NONE;
    assign rd_strobe = ce_act && !oe_s_n;
    assign wr_strobe = ce_act && oe_s_n && !we_s_n;

    pcm_card_state_e state;
    pcm_lane_e lane;
    logic odd;
    pcm_data_t rd_q;

    // ============================================================
    // cycle sequencer
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || reset_s)
        begin
            state <= PCM_C_IDLE;
        end
        else
        begin
            case (state)
                PCM_C_IDLE:
                begin
                    if (rd_strobe || wr_strobe)
                    begin
                        state <= PCM_C_WAIT;
                    end
                end
                PCM_C_WAIT:
                begin
                    // an abandoned cycle still waits for the ack so
                    // the user side is never left with a request
                    if (usr_ack)
                    begin
                        state <= PCM_C_HOLD;
                    end
                end
                PCM_C_HOLD:
                begin
                    if (!ce_act)
                    begin
                        state <= PCM_C_IDLE;
                    end
                end
                default:
                begin
                    state <= PCM_C_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // request toward the user side
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || reset_s)
        begin
            usr_req <= 1'b0;
        end
        else
        begin
            usr_req <= state == PCM_C_IDLE && (rd_strobe || wr_strobe);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            usr_wr <= 1'b0;
            usr_attr <= 1'b0;
            usr_addr <= '0;
            lane <= PCM_LANE_NONE;
            odd <= 1'b0;
        end
        else if (state == PCM_C_IDLE && (rd_strobe || wr_strobe))
        begin
            usr_wr <= wr_strobe;
            usr_attr <= !reg_s_n;
            usr_addr <= a_s;
            lane <= lane_s;
            odd <= a_s[0];
        end
    end

    // byte steering of the write lanes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            usr_be <= `PCM_BE_NONE;
            usr_wdata <= '0;
        end
        else if (state == PCM_C_IDLE && (rd_strobe || wr_strobe))
        begin
            case (lane_s)
                PCM_LANE_LOW:
                begin
                    usr_be <= a_s[0] ? `PCM_BE_HIGH : `PCM_BE_LOW;
                    usr_wdata <= {d_s[7:0], d_s[7:0]};
                end
                PCM_LANE_HIGH:
                begin
                    usr_be <= `PCM_BE_HIGH;
                    usr_wdata <= {d_s[15:8], `PCM_BYTE_ZERO};
                end
                PCM_LANE_WORD:
                begin
                    usr_be <= `PCM_BE_WORD;
                    usr_wdata <= d_s;
                end
                default:
                begin
                    usr_be <= `PCM_BE_NONE;
                    usr_wdata <= '0;
                end
            endcase
        end
    end

    // ============================================================
    // read data steering
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rd_q <= '0;
        end
        else if (state == PCM_C_WAIT && usr_ack && !usr_wr)
        begin
            case (lane)
                PCM_LANE_LOW:
                begin
                    rd_q <= {`PCM_BYTE_ZERO,
                             odd ? usr_rdata[15:8] : usr_rdata[7:0]};
                end
                PCM_LANE_HIGH:
                begin
                    rd_q <= {usr_rdata[15:8], `PCM_BYTE_ZERO};
                end
                default:
                begin
                    rd_q <= usr_rdata;
                end
            endcase
        end
    end

    // ============================================================
    // pin drivers
    // lanes are released as soon as the synced oe rises; the host
    // must not drive before its own gap, which covers our latency
    logic drive_rd;

    assign drive_rd = state == PCM_C_HOLD && !usr_wr && rd_strobe;
    assign bus.c_d_o = rd_q;
    assign bus.c_d_oe[0] = drive_rd && lane[0];
    assign bus.c_d_oe[1] = drive_rd && lane[1];
    assign bus.c_wait_o = 1'b0;
    assign bus.c_wait_oe = state == PCM_C_WAIT;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cfg_reset <= 1'b1;
        end
        else
        begin
            cfg_reset <= reset_s;
        end
    end

endmodule

// >>> pcm_host.sv
// host end: socket controller issuing 16-bit card memory cycles
// assumes the card answers through wait; one command at a time
`timescale 1ns/1ps
`include "pcm_defines.svh"

module pcm_host
(
    input wire logic ref_clk,
    input wire logic rst_n,
    pcm_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_wr,
    input wire logic cmd_attr,
    input wire pcm_pkg::pcm_addr_t cmd_addr,
    input wire logic [1:0] cmd_be,
    input wire pcm_pkg::pcm_data_t cmd_wdata,
    output logic rsp_valid,
    output pcm_pkg::pcm_data_t rsp_rdata,
    input wire logic card_reset
);
    import pcm_pkg::*;

    // ============================================================
    // synchronisers for what the card drives
    logic [`PCM_DATA_W:0] sync1;
    logic [`PCM_DATA_W:0] sync2;
    logic wait_s_n;
    pcm_data_t d_s;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sync1 <= '1;
            sync2 <= '1;
        end
        else
        begin
            sync1 <= {bus.wait_n, bus.data};
            sync2 <= sync1;
        end
    end
    assign {wait_s_n, d_s} = sync2;

    // ============================================================
    // cycle sequencer
    pcm_host_state_e state;
    logic [7:0] cnt;
    logic rd;

    assign cmd_ready = state == PCM_H_IDLE && !card_reset;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state <= PCM_H_IDLE;
            cnt <= `PCM_CNT_ZERO;
            rd <= 1'b0;
            bus.addr <= '0;
            bus.reg_n <= 1'b1;
            bus.ce1_n <= 1'b1;
            bus.ce2_n <= 1'b1;
            bus.oe_n <= 1'b1;
            bus.we_n <= 1'b1;
            bus.h_d_o <= '0;
            bus.h_d_oe <= 2'b00;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            case (state)
                PCM_H_IDLE:
                begin
                    if (cmd_valid && cmd_ready)
                    begin
                        rd <= !cmd_wr;
                        bus.addr <= cmd_addr;
                        bus.reg_n <= !cmd_attr;
                        // an empty byte enable is sent as a word
                        bus.ce1_n <= cmd_be == `PCM_BE_HIGH;
                        bus.ce2_n <= cmd_be == `PCM_BE_LOW;
                        bus.h_d_o <= cmd_be == `PCM_BE_LOW ?
                            {`PCM_BYTE_ZERO, cmd_wdata[7:0]} : cmd_wdata;
                        bus.h_d_oe[0] <= cmd_wr && cmd_be != `PCM_BE_HIGH;
                        bus.h_d_oe[1] <= cmd_wr && cmd_be != `PCM_BE_LOW;
                        cnt <= `PCM_SETUP_CYC;
                        state <= PCM_H_SETUP;
                    end
                end
                PCM_H_SETUP:
                begin
                    cnt <= cnt - `PCM_CNT_ONE;
                    if (cnt == `PCM_CNT_ONE)
                    begin
                        bus.oe_n <= !rd;
                        bus.we_n <= rd;
                        cnt <= `PCM_STROBE_CYC;
                        state <= PCM_H_STROBE;
                    end
                end
                PCM_H_STROBE:
                begin
                    // minimum width covers both synchroniser delays
                    if (cnt != `PCM_CNT_ZERO)
                    begin
                        cnt <= cnt - `PCM_CNT_ONE;
                    end
                    else if (wait_s_n)
                    begin
                        bus.oe_n <= 1'b1;
                        bus.we_n <= 1'b1;
                        rsp_valid <= 1'b1;
                        rsp_rdata <= rd ? d_s : '0;
                        cnt <= `PCM_HOLD_CYC;
                        state <= PCM_H_HOLD;
                    end
                end
                PCM_H_HOLD:
                begin
                    cnt <= cnt - `PCM_CNT_ONE;
                    if (cnt == `PCM_CNT_ONE)
                    begin
                        bus.ce1_n <= 1'b1;
                        bus.ce2_n <= 1'b1;
                        bus.reg_n <= 1'b1;
                        bus.h_d_oe <= 2'b00;
                        cnt <= `PCM_GAP_CYC;
                        state <= PCM_H_GAP;
                    end
                end
                PCM_H_GAP:
                begin
                    cnt <= cnt - `PCM_CNT_ONE;
                    if (cnt == `PCM_CNT_ONE)
                    begin
                        state <= PCM_H_IDLE;
                    end
                end
                default:
                begin
                    state <= PCM_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            bus.bus_reset <= 1'b1;
        end
        else
        begin
            bus.bus_reset <= card_reset;
        end
    end

endmodule

// >>> pcm_props.sv
// checker on the pins that join the socket host and the card target
// assumes it sits beside pcm_if and shares the link's ref_clk and rst_n
`timescale 1ns/1ps
`include "pcm_defines.svh"

module pcm_props
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [`PCM_ADDR_W-1:0] addr,
    input wire logic reg_n,
    input wire logic ce1_n,
    input wire logic ce2_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic bus_reset,
    input wire logic [1:0] h_d_oe,
    input wire logic [1:0] c_d_oe,
    input wire logic c_wait_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ============================================================
    // framing and strobes
    wire logic frame = !ce1_n || !ce2_n;

    chk_strobe_excl: assert property (!(!oe_n && !we_n))
        else $error("read and write strobes low together");
    chk_strobe_frame: assert property ((!oe_n || !we_n) |-> frame)
        else $error("strobe low outside a card enable frame");
    chk_addr_hold: assert property (frame && $past(frame) |->
        $stable(addr) && $stable(reg_n))
        else $error("address or space select moved inside a frame");

    // ============================================================
    // data lanes
    chk_no_clash: assert property ((c_d_oe & h_d_oe) == 2'b00)
        else $error("host and card drive one lane together");
    chk_read_only: assert property ((c_d_oe != 2'b00) |-> we_n)
        else $error("card drives data during a write");
    chk_lane_steer: assert property ($fell(c_wait_oe) && !oe_n |->
        ##[0:1] (c_d_oe == {!ce2_n, !ce1_n}))
        else $error("card read lanes do not follow the enables");

    // ============================================================
    // wait stretching and reset
    chk_wait_rise: assert property ($fell(oe_n) |-> ##[1:6] c_wait_oe)
        else $error("card did not stretch a read with wait");
    chk_wait_strobe: assert property (c_wait_oe |-> (!oe_n || !we_n))
        else $error("host ended a strobe while wait was low");
    chk_host_ends: assert property ($fell(c_wait_oe) |->
        ##[1:12] (oe_n && we_n))
        else $error("host kept the strobe long after wait release");
    chk_reset_idle: assert property (bus_reset [*4] |->
        (c_d_oe == 2'b00 && !c_wait_oe))
        else $error("card still active under bus reset");
endmodule

// >>> pcm_card_memory_cycle_target_tb.sv
// bench: host end and card end joined by one link, memory on user side
// assumes both ends share ref_clk and rst_n
`timescale 1ns/1ps
`include "pcm_defines.svh"

module pcm_card_memory_cycle_target_tb;
    import pcm_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_wr = 1'b0;
    logic cmd_attr = 1'b0;
    pcm_addr_t cmd_addr = '0;
    logic [1:0] cmd_be = 2'h3;
    pcm_data_t cmd_wdata = '0;
    logic card_reset = 1'b0;
    logic usr_ack = 1'b0;
    pcm_data_t usr_rdata = '0;
    logic cmd_ready, rsp_valid, usr_req, usr_wr, usr_attr, cfg_reset;
    pcm_data_t rsp_rdata, usr_wdata;
    pcm_addr_t usr_addr;
    logic [1:0] usr_be;
    logic [15:0] mem [logic [26:0]];
    logic [29:0] exp_req;
    pcm_data_t exp_wd, exp_wm;
    logic [31:0] seed = 32'h00010576;
    bit slow = 1'b0;
    int n_errors = 0;
    int tests_run = 0;
    int n_req = 0;
    int n_cmd = 0;

    pcm_if bus_if ();
    pcm_host i_pcm_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_wr(cmd_wr),
        .cmd_attr(cmd_attr), .cmd_addr(cmd_addr), .cmd_be(cmd_be),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .card_reset(card_reset));
    pcm_card i_pcm_card (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if),
        .usr_req(usr_req), .usr_wr(usr_wr), .usr_attr(usr_attr),
        .usr_addr(usr_addr), .usr_be(usr_be), .usr_wdata(usr_wdata),
        .usr_ack(usr_ack), .usr_rdata(usr_rdata), .cfg_reset(cfg_reset));
    pcm_props i_pcm_props (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(bus_if.addr), .reg_n(bus_if.reg_n), .ce1_n(bus_if.ce1_n),
        .ce2_n(bus_if.ce2_n), .oe_n(bus_if.oe_n), .we_n(bus_if.we_n),
        .bus_reset(bus_if.bus_reset), .h_d_oe(bus_if.h_d_oe),
        .c_d_oe(bus_if.c_d_oe), .c_wait_oe(bus_if.c_wait_oe));

    // ============================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic pcm_data_t getw(input logic [26:0] k);
        return mem.exists(k) ? mem[k] : 16'h0000;
    endfunction

    // undriven lane reads back as the idle level
    function automatic pcm_data_t exp_rd(input pcm_data_t w,
                                         input logic [1:0] be,
                                         input logic a0);
        if (be == 2'h1)
            return {8'hFF, a0 ? w[15:8] : w[7:0]};
        if (be == 2'h2)
            return {w[15:8], 8'hFF};
        return w;
    endfunction

    task automatic cmp_data(input pcm_data_t got, input pcm_data_t exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_req(input logic [29:0] got, input logic [29:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("counts: tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one host command, entered and left just after a rising edge
    task automatic do_cmd(input logic wr, input logic attr, input pcm_addr_t a,
                          input logic [1:0] be, input pcm_data_t wd);
        logic [1:0] ube;
        logic [26:0] k;
        pcm_data_t w;
        pcm_data_t e;
        int n;
        ube = (be == 2'h0) ? 2'h3 : be;
        k = {attr, a[25:1]};
        w = getw(k);
        // an odd byte on the low lane reaches the user as a high enable
        exp_req = {wr, attr, (ube == 2'h1 && a[0]) ? 2'h2 : ube, a};
        exp_wm = (ube == 2'h2) ? 16'hFF00 : 16'hFFFF;
        exp_wd = (ube == 2'h1) ? {wd[7:0], wd[7:0]} : wd;
        e = wr ? 16'h0000 : exp_rd(w, ube, a[0]);
        n_cmd++;
        {cmd_wr, cmd_attr, cmd_addr, cmd_be, cmd_wdata} = {wr, attr, a, be, wd};
        cmd_valid = 1'b1;
        for (n = 0; cmd_ready !== 1'b1 && n < 200; n++)
            #8;
        if (n >= 200)
            n_errors++;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        for (n = 0; rsp_valid !== 1'b1 && n < 400; n++)
            #8;
        if (n >= 400)
            n_errors++;
        cmp_data(rsp_rdata, e);
        if (wr && (ube == 2'h2 || (ube == 2'h1 && a[0])))
            w[15:8] = (ube == 2'h2) ? wd[15:8] : wd[7:0];
        else if (wr && ube == 2'h1)
            w[7:0] = wd[7:0];
        else if (wr)
            w = wd;
        mem[k] = w;
    endtask

    // ============================================================
    // clock, user side memory, watchdog
    initial
        forever
            #4 ref_clk = ~ref_clk;

    initial
    begin : responder
        int d;
        forever
        begin
            @(posedge ref_clk);
            #1;
            if (usr_req === 1'b1)
            begin
                n_req++;
                cmp_req({usr_wr, usr_attr, usr_be, usr_addr}, exp_req);
                if (usr_wr === 1'b1)
                    cmp_data(usr_wdata & exp_wm, exp_wd & exp_wm);
                d = slow ? 40 : int'(rnd() % 4);
                #(8 * d);
                usr_rdata = getw({usr_attr, usr_addr[25:1]});
                usr_ack = 1'b1;
                @(posedge ref_clk);
                #1;
                usr_ack = 1'b0;
                usr_rdata = ~usr_rdata;
            end
        end
    end

    // the whole run needs a few thousand cycles
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        n_errors++;
        conclude();
    end

    // ============================================================
    // tests
    initial
    begin
        pcm_addr_t a;
        repeat (20) @(posedge ref_clk);
        #1;
        cmp_data({15'h0000, cfg_reset}, 16'h0001);
        rst_n = 1'b1;
        #64;
        for (int i = 0; i < 16; i++)
        begin
            a = pcm_addr_t'(rnd());
            a[0] = i[0];
            do_cmd(1'b1, i[1], a, i[3:2], pcm_data_t'(rnd()));
            do_cmd(1'b0, i[1], a, i[3:2], 16'h0000);
        end
        $display("test lanes done");
        for (int j = 0; j < 4; j++)
        begin
            a = j[0] ? 26'h3FFFFFF : 26'h0000000;
            do_cmd(1'b1, j[1], a, 2'h3, 16'h8001);
            do_cmd(1'b0, j[1], a, 2'h3, 16'h0000);
        end
        $display("test address ends done");
        for (int r = 0; r < 40; r++)
        begin
            a = pcm_addr_t'(rnd() & 32'h0000003F);
            do_cmd(1'(rnd()), 1'(rnd()), a, 2'(rnd()), 16'(rnd()));
        end
        $display("test random done");
        slow = 1'b1;
        do_cmd(1'b1, 1'b0, 26'h0000010, 2'h3, 16'hA55A);
        do_cmd(1'b0, 1'b0, 26'h0000010, 2'h3, 16'h0000);
        slow = 1'b0;
        $display("test long wait done");
        card_reset = 1'b1;
        #48;
        cmp_data({15'h0000, cfg_reset}, 16'h0001);
        cmp_data({15'h0000, cmd_ready}, 16'h0000);
        card_reset = 1'b0;
        #64;
        cmp_data({15'h0000, cfg_reset}, 16'h0000);
        do_cmd(1'b0, 1'b0, 26'h0000011, 2'h1, 16'h0000);
        $display("test bus reset done");
        cmp_req(30'(n_req), 30'(n_cmd));
        conclude();
    end
endmodule
